// file: pfhc_regs.svh
/*
 * Constants for the parallel flash host controller: APB offsets, control
 * fields, command words and pin timing counts.
 * Assumes pclk at 25 MHz and a byte-wide asynchronous flash on the pins.
 */
`ifndef PFHC_REGS_SVH
`define PFHC_REGS_SVH

// APB register offsets
`define PFHC_CTRL_OFS 12'h000
`define PFHC_ADDR_OFS 12'h004
`define PFHC_WDATA_OFS 12'h008
`define PFHC_RDATA_OFS 12'h00c
`define PFHC_STATUS_OFS 12'h010

// Control fields
`define PFHC_CTRL_OP_LSB 0
`define PFHC_CTRL_GO_BIT 3
`define PFHC_CTRL_HV_BIT 4
`define PFHC_CTRL_ABORT_BIT 5
`define PFHC_CTRL_RST 32'h0000_0000

// Status fields
`define PFHC_ST_BUSY_BIT 0
`define PFHC_ST_READY_BIT 1
`define PFHC_ST_REISSUE_BIT 2
`define PFHC_ST_HV_BIT 3

// Command words
`define PFHC_UNLOCK_A1 20'h05555
`define PFHC_UNLOCK_A2 20'h02aaa
`define PFHC_UNLOCK_D1 8'haa
`define PFHC_UNLOCK_D2 8'h55
`define PFHC_CMD_SETUP 8'h80
`define PFHC_CMD_ERASE 8'h10
`define PFHC_CMD_PROG 8'ha0
`define PFHC_CMD_LOCK 8'h40
`define PFHC_CMD_ID_ENTRY 8'h90
`define PFHC_CMD_ID_EXIT 8'hf0
`define PFHC_BOOT_LAST 20'h03fff
`define PFHC_LOCK_STATUS_ADDR 20'h00002

// Timing
`define PFHC_CLK_NS 40
`define PFHC_GLITCH_NS 15
`define PFHC_ACCESS_NS 110
`define PFHC_RESET_NS 500
`define PFHC_STROBE_CYC ((`PFHC_GLITCH_NS + `PFHC_CLK_NS - 1) / `PFHC_CLK_NS + 1)
`define PFHC_READ_CYC ((`PFHC_ACCESS_NS + `PFHC_CLK_NS - 1) / `PFHC_CLK_NS + 2)
`define PFHC_RESET_CYC ((`PFHC_RESET_NS + `PFHC_CLK_NS - 1) / `PFHC_CLK_NS)

`endif

// file: pfhc_pkg.sv
/*
 * Types for the parallel flash host controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pfhc_pkg;
    typedef enum logic [2:0] {
        PFHC_OP_READ = 3'b000,
        PFHC_OP_PROG = 3'b001,
        PFHC_OP_ERASE = 3'b010,
        PFHC_OP_LOCK = 3'b011,
        PFHC_OP_ID_ENTRY = 3'b100,
        PFHC_OP_ID_EXIT = 3'b101,
        PFHC_OP_ID_EXIT1 = 3'b110,
        PFHC_OP_RESET = 3'b111
    } pfhc_op_e;

    typedef enum logic [2:0] {
        PFHC_S_IDLE = 3'b000,
        PFHC_S_WORD = 3'b001,
        PFHC_S_WAIT = 3'b010,
        PFHC_S_POLL = 3'b011,
        PFHC_S_POLLW = 3'b100,
        PFHC_S_RST = 3'b101
    } pfhc_state_e;

    typedef enum logic [1:0] {
        PFHC_C_IDLE = 2'b00,
        PFHC_C_SETUP = 2'b01,
        PFHC_C_STROBE = 2'b10,
        PFHC_C_HOLD = 2'b11
    } pfhc_cyc_e;
endpackage

// file: pfhc_bus_cycle.sv
/*
 * One flash bus cycle, write or read, on the flash pins.
 * Assumes start only while idle and data_sync already synchronised.
 */
`timescale 1ns/10ps
`include "pfhc_regs.svh"

module pfhc_bus_cycle import pfhc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic is_write,
    input wire logic [19:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] data_sync,
    output logic done,
    output logic [7:0] rdata,
    output logic [19:0] byte_address_lines,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe
);
    pfhc_cyc_e st_reg, st_next;
    logic [2:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next;
    logic [19:0] addr_reg, addr_next;
    logic [7:0] wd_reg, wd_next;
    logic [7:0] rd_reg, rd_next;
    logic ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next, drv_reg, drv_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        addr_next = addr_reg;
        wd_next = wd_reg;
        rd_next = rd_reg;
        ce_next = ce_reg;
        oe_next = oe_reg;
        we_next = we_reg;
        drv_next = drv_reg;
        case (st_reg)
            PFHC_C_IDLE: begin
                if (start) begin
                    // Address settles before any strobe falls
                    st_next = PFHC_C_SETUP;
                    wr_next = is_write;
                    addr_next = addr;
                    wd_next = wdata;
                    ce_next = 1'b0;
                    oe_next = 1'b1;
                    we_next = 1'b1;
                    drv_next = is_write;
                end
            end
            PFHC_C_SETUP: begin
                st_next = PFHC_C_STROBE;
                cnt_next = 3'h0;
                if (wr_reg) begin
                    we_next = 1'b0; // Gate held high while strobing
                end else begin
                    oe_next = 1'b0; // Strobe high, gate low: array read
                end
            end
            PFHC_C_STROBE: begin
                cnt_next = cnt_reg + 3'h1;
                // Strobe far longer than the noise filter window
                if (wr_reg && cnt_reg == 3'(`PFHC_STROBE_CYC - 1)) begin
                    we_next = 1'b1;
                    st_next = PFHC_C_HOLD;
                end else if (!wr_reg && cnt_reg == 3'(`PFHC_READ_CYC - 1)) begin
                    rd_next = data_sync;
                    oe_next = 1'b1;
                    st_next = PFHC_C_HOLD;
                end
            end
            PFHC_C_HOLD: begin
                // Data held past the rising strobe edge that latches it
                ce_next = 1'b1;
                drv_next = 1'b0;
                st_next = PFHC_C_IDLE;
            end
            default: st_next = PFHC_C_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= PFHC_C_IDLE;
            cnt_reg <= 3'h0;
            wr_reg <= 1'b0;
            addr_reg <= 20'h00000;
            wd_reg <= 8'h00;
            rd_reg <= 8'h00;
            ce_reg <= 1'b1;
            oe_reg <= 1'b1;
            we_reg <= 1'b1;
            drv_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            addr_reg <= addr_next;
            wd_reg <= wd_next;
            rd_reg <= rd_next;
            ce_reg <= ce_next;
            oe_reg <= oe_next;
            we_reg <= we_next;
            drv_reg <= drv_next;
        end
    end

    assign done = (st_reg == PFHC_C_HOLD);
    assign rdata = rd_reg;
    assign byte_address_lines = addr_reg;
    assign chip_select_n = ce_reg;
    assign output_gate_n = oe_reg;
    assign write_strobe_n = we_reg;
    assign data_lines_o = wd_reg;
    assign data_lines_oe = drv_reg;
endmodule

// file: pfhc_host.sv
/*
 * Host controller for a byte-wide asynchronous flash: APB registers take
 * orders, command sequences and polling run on the flash pins.
 * Assumes one clock pclk at 25 MHz; flash inputs arrive asynchronously.
 */
`timescale 1ns/10ps
`include "pfhc_regs.svh"

module pfhc_host import pfhc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [19:0] byte_address_lines,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n,
    output logic flash_reset_n,
    output logic reset_override_en,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic [7:0] data_lines_i,
    input wire logic done_flag_i
);
    pfhc_state_e st_reg, st_next;
    pfhc_op_e op_reg, op_next;
    logic [2:0] step_reg, step_next;
    logic [19:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic hv_reg, hv_next, reissue_reg, reissue_next;
    logic prev6_reg, prev6_next, have_prev_reg, have_prev_next;
    logic [4:0] rcnt_reg, rcnt_next;
    logic [7:0] dq_s1_reg, dq_s2_reg;
    logic rdy_s1_reg, rdy_s2_reg;
    logic cyc_start, cyc_write, cyc_done;
    logic [19:0] cyc_addr;
    logic [7:0] cyc_wdata, cyc_rdata;
    logic [28:0] word;
    logic wr_acc, mapped;

    // Returns {last, address, data} of one step of a command sequence
    function automatic logic [28:0] seq_word(input pfhc_op_e op, input logic [2:0] step,
                                             input logic [19:0] ua, input logic [7:0] ud);
        logic [7:0] code;
        code = `PFHC_CMD_ID_ENTRY;
        if (op == PFHC_OP_READ) begin
            return {1'b1, ua, 8'h00};
        end
        if (op == PFHC_OP_ID_EXIT1) begin
            return {1'b1, ua, `PFHC_CMD_ID_EXIT}; // Single-write exit
        end
        if (op == PFHC_OP_ERASE) begin
            code = `PFHC_CMD_ERASE;
        end else if (op == PFHC_OP_LOCK) begin
            code = `PFHC_CMD_LOCK;
        end else if (op == PFHC_OP_ID_EXIT) begin
            code = `PFHC_CMD_ID_EXIT;
        end
        // Unlock pair, then command code
        case (step)
            3'h0: return {1'b0, `PFHC_UNLOCK_A1, `PFHC_UNLOCK_D1};
            3'h1: return {1'b0, `PFHC_UNLOCK_A2, `PFHC_UNLOCK_D2};
            3'h2: begin
                if (op == PFHC_OP_PROG) begin
                    return {1'b0, `PFHC_UNLOCK_A1, `PFHC_CMD_PROG};
                end else if (op == PFHC_OP_ERASE || op == PFHC_OP_LOCK) begin
                    return {1'b0, `PFHC_UNLOCK_A1, `PFHC_CMD_SETUP};
                end
                return {1'b1, `PFHC_UNLOCK_A1, code};
            end
            3'h3: begin
                if (op == PFHC_OP_PROG) begin
                    return {1'b1, ua, ud}; // Fourth write carries target
                end
                return {1'b0, `PFHC_UNLOCK_A1, `PFHC_UNLOCK_D1};
            end
            3'h4: return {1'b0, `PFHC_UNLOCK_A2, `PFHC_UNLOCK_D2};
            default: return {1'b1, `PFHC_UNLOCK_A1, code};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_s1_reg <= 8'hff;
            dq_s2_reg <= 8'hff;
            rdy_s1_reg <= 1'b1;
            rdy_s2_reg <= 1'b1;
        end else begin
            dq_s1_reg <= data_lines_i;
            dq_s2_reg <= dq_s1_reg;
            rdy_s1_reg <= done_flag_i;
            rdy_s2_reg <= rdy_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign mapped = (paddr == `PFHC_CTRL_OFS) || (paddr == `PFHC_ADDR_OFS) ||
                    (paddr == `PFHC_WDATA_OFS) || (paddr == `PFHC_RDATA_OFS) ||
                    (paddr == `PFHC_STATUS_OFS);
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `PFHC_CTRL_OFS: prdata = {27'h0, hv_reg, 1'b0, 3'(op_reg)};
            `PFHC_ADDR_OFS: prdata = {12'h000, addr_reg};
            `PFHC_WDATA_OFS: prdata = {24'h000000, wdata_reg};
            `PFHC_RDATA_OFS: prdata = {24'h000000, rdata_reg};
            `PFHC_STATUS_OFS: prdata = {28'h0, hv_reg, reissue_reg, rdy_s2_reg,
                                        st_reg != PFHC_S_IDLE};
            default: prdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign word = seq_word(op_reg, step_reg, addr_reg, wdata_reg);

    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        step_next = step_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        hv_next = hv_reg;
        reissue_next = reissue_reg;
        prev6_next = prev6_reg;
        have_prev_next = have_prev_reg;
        rcnt_next = rcnt_reg;
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        cyc_addr = word[27:8];
        cyc_wdata = word[7:0];
        if (wr_acc && st_reg == PFHC_S_IDLE) begin
            if (paddr == `PFHC_ADDR_OFS) begin
                addr_next = pwdata[19:0];
            end
            if (paddr == `PFHC_WDATA_OFS) begin
                wdata_next = pwdata[7:0];
            end
        end
        if (wr_acc && paddr == `PFHC_CTRL_OFS) begin
            // Override voltage switch; lockout returns once dropped
            hv_next = pwdata[`PFHC_CTRL_HV_BIT];
        end
        case (st_reg)
            PFHC_S_IDLE: begin
                if (wr_acc && paddr == `PFHC_CTRL_OFS && pwdata[`PFHC_CTRL_GO_BIT]) begin
                    op_next = pfhc_op_e'(pwdata[`PFHC_CTRL_OP_LSB +: 3]);
                    step_next = 3'h0;
                    reissue_next = 1'b0;
                    rcnt_next = 5'h00;
                    st_next = (pwdata[`PFHC_CTRL_OP_LSB +: 3] == 3'(PFHC_OP_RESET)) ?
                              PFHC_S_RST : PFHC_S_WORD;
                end
            end
            PFHC_S_WORD: begin
                cyc_start = 1'b1;
                cyc_write = (op_reg != PFHC_OP_READ);
                st_next = PFHC_S_WAIT;
            end
            PFHC_S_WAIT: begin
                if (cyc_done) begin
                    if (op_reg == PFHC_OP_READ) begin
                        rdata_next = cyc_rdata; // 00002H in ID mode gives lockout
                        st_next = PFHC_S_IDLE;
                    end else if (!word[28]) begin
                        step_next = step_reg + 3'h1;
                        st_next = PFHC_S_WORD;
                    end else if (op_reg == PFHC_OP_PROG || op_reg == PFHC_OP_ERASE ||
                                 op_reg == PFHC_OP_LOCK) begin
                        have_prev_next = 1'b0;
                        st_next = PFHC_S_POLL;
                    end else begin
                        st_next = PFHC_S_IDLE;
                    end
                end
            end
            PFHC_S_POLL: begin
                // Read back the last loaded address while self-timed work runs
                cyc_start = 1'b1;
                cyc_write = 1'b0;
                cyc_addr = addr_reg;
                st_next = PFHC_S_POLLW;
            end
            PFHC_S_POLLW: begin
                if (cyc_done) begin
                    prev6_next = cyc_rdata[6];
                    have_prev_next = 1'b1;
                    // Finished when bit six stops toggling and flag released
                    if (have_prev_reg && cyc_rdata[6] == prev6_reg && rdy_s2_reg) begin
                        rdata_next = cyc_rdata;
                        st_next = PFHC_S_IDLE;
                    end else begin
                        st_next = PFHC_S_POLL;
                    end
                end
            end
            PFHC_S_RST: begin
                rcnt_next = rcnt_reg + 5'h01;
                if (rcnt_reg == 5'(`PFHC_RESET_CYC - 1)) begin
                    rcnt_next = 5'h00;
                    // Interrupted program or erase is started again
                    if (op_reg == PFHC_OP_PROG || op_reg == PFHC_OP_ERASE ||
                        op_reg == PFHC_OP_LOCK) begin
                        step_next = 3'h0;
                        reissue_next = 1'b1;
                        st_next = PFHC_S_WORD;
                    end else begin
                        st_next = PFHC_S_IDLE;
                    end
                end
            end
            default: st_next = PFHC_S_IDLE;
        endcase
        // Abort only between pin cycles so no strobe is cut short
        if (wr_acc && paddr == `PFHC_CTRL_OFS && pwdata[`PFHC_CTRL_ABORT_BIT] &&
            st_reg == PFHC_S_POLL) begin
            // No poll read is launched into the reset pulse
            cyc_start = 1'b0;
            rcnt_next = 5'h00;
            st_next = PFHC_S_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= PFHC_S_IDLE;
            op_reg <= PFHC_OP_READ;
            step_reg <= 3'h0;
            addr_reg <= 20'h00000;
            wdata_reg <= 8'hff;
            rdata_reg <= 8'h00;
            hv_reg <= 1'b0;
            reissue_reg <= 1'b0;
            prev6_reg <= 1'b0;
            have_prev_reg <= 1'b0;
            rcnt_reg <= 5'h00;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            step_reg <= step_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            hv_reg <= hv_next;
            reissue_reg <= reissue_next;
            prev6_reg <= prev6_next;
            have_prev_reg <= have_prev_next;
            rcnt_reg <= rcnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash reset held low for a fixed time, pins idle meanwhile
    assign flash_reset_n = (st_reg != PFHC_S_RST);
    assign reset_override_en = hv_reg;

    pfhc_bus_cycle u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .data_sync(dq_s2_reg),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .byte_address_lines(byte_address_lines),
        .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n),
        .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe)
    );
endmodule

// file: pfhc_flash_model.sv
/* Behavioural byte-wide flash that stands on the host controller's pins.
   Assumes the bench resolves the data lines. */
`timescale 1ns/10ps
module pfhc_flash_model #(
    parameter int PROG_NS = 4000,
    parameter int ERASE_NS = 6000,
    parameter logic [7:0] MFR_CODE = 8'h5c, // Arbitrary
    parameter logic [7:0] DEV_CODE = 8'ha7 // Arbitrary
) (
    input wire logic [19:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    input wire logic hv,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic drv,
    output logic rdy
);
    logic [7:0] mem [int];
    logic [19:0] la = 0, pa = 0;
    logic [7:0] pd = 0;
    logic [1:0] st = 0, op = 0;
    logic su = 0, pg = 0, idm = 0, lock = 0, busy = 0, t6 = 0;
    int tok = 0;
    wire wstb = ce_n | we_n;
    function automatic logic [7:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    task automatic go(input logic [1:0] k, input int ns);
        int t;
        op = k;
        busy = 1;
        tok++;
        t = tok;
        fork
            begin
                #(ns);
                if (busy && t == tok) begin
                    if (op == 1 && (!lock || hv || pa > 20'h03fff)) mem[pa] = rd(pa) & pd;
                    if (op == 3) lock = 1;
                    if (op == 2) foreach (mem[j]) if (!lock || hv || j > 20'h03fff) mem[j] = 8'hff;
                    busy = 0;
                end
            end
        join_none
    endtask
    assign drv = rst_n && !ce_n && !oe_n && we_n;
    assign rdy = !busy;
    always @(addr, busy, idm, t6, lock)
        dout = busy ? {~pd[7], t6, pd[5:0]} :
            (idm && addr == 2) ? {7'h0, lock} : (idm && addr == 0) ? MFR_CODE :
            (idm && addr == 1) ? DEV_CODE : rd(addr);
    always @(negedge oe_n) if (busy && !ce_n) t6 = ~t6;
    always @(negedge wstb) la = addr;
    always @(negedge rst_n) begin
        busy = 0;
        st = 0;
        su = 0;
        pg = 0;
    end
    // Data taken at the first rising strobe never with gate low
    always @(posedge wstb) if (rst_n && oe_n && !busy) begin
        if (pg) begin
            pg = 0;
            pa = la;
            pd = din;
            go(1, PROG_NS);
        end else if (st == 0 && din == 8'hf0) idm = 0;
        else if (st == 0 && la == 20'h05555 && din == 8'haa) st = 1;
        else if (st == 1 && la == 20'h02aaa && din == 8'h55) st = 2;
        else begin
            if (st == 2 && la == 20'h05555) begin
                pg = !su && din == 8'ha0;
                if (!su && din == 8'h90) idm = 1;
                if (din == 8'hf0) idm = 0;
                if (su && din == 8'h10) go(2, ERASE_NS);
                if (su && din == 8'h40) go(3, PROG_NS);
                su = !su && din == 8'h80;
            end else su = 0;
            st = 0;
        end
    end
endmodule

// file: pfhc_host_assertions.sv
/* Pin protocol checks for the flash host controller.
   Assumes binding to pfhc_host and its single pclk domain. */
`timescale 1ns/10ps
module pfhc_host_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [19:0] byte_address_lines,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic flash_reset_n,
    input wire logic [7:0] data_lines_o,
    input wire logic data_lines_oe,
    input wire logic done_flag_i
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_STROBE_WIDTH: assert property ($fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
        else $error("write strobe width wrong");
    AST_DATA_HELD: assert property (!write_strobe_n |-> data_lines_oe && $stable(data_lines_o)
        && $stable(byte_address_lines)) else $error("write data or address moved");
    AST_WE_RELEASE: assert property ($rose(write_strobe_n) |-> !chip_select_n ##1 chip_select_n)
        else $error("select not held past strobe");
    AST_WE_GATED: assert property (!write_strobe_n |-> output_gate_n && !chip_select_n)
        else $error("strobe without select or with gate");
    AST_READ_SETUP: assert property ($fell(output_gate_n) |-> !chip_select_n && !data_lines_oe)
        else $error("read started badly");
    AST_READ_WIDTH: assert property ($fell(output_gate_n) |=> !output_gate_n[*4] ##1 output_gate_n)
        else $error("gate width wrong");
    AST_OE_DRIVE: assert property (data_lines_oe |-> output_gate_n)
        else $error("host drives against flash");
    AST_RESET_PULSE: assert property ($fell(flash_reset_n) |=> !flash_reset_n[*8] ##1
        !flash_reset_n[*4] ##1 flash_reset_n) else $error("flash reset width wrong");
    AST_BUSY_NO_WRITE: assert property (!done_flag_i && !$past(done_flag_i, 3) |-> write_strobe_n)
        else $error("write while flash busy");
    cover property ($fell(write_strobe_n));
    cover property ($fell(output_gate_n));
    cover property ($fell(flash_reset_n));
endmodule

// file: testbench.sv
/* Self-checking bench: APB orders to the host, flash model on its pins.
   Assumes the flash model and the checker compile before it. */
`timescale 1ns/10ps
`include "pfhc_regs.svh"
module testbench import pfhc_pkg::*;;
    localparam logic [7:0] MFR = 8'h5c; // Arbitrary
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h0001_8256;
    logic pready, pslverr, ce_n, oe_n, we_n, frst_n, hv, h_oe, f_drv, f_rdy;
    logic [19:0] fa, a;
    logic [7:0] h_o, f_d, d_i, d, d2;
    logic [31:0] eq[$], mq[$];
    int mismatches = 0, checks = 0, i;
    always #20 pclk = ~pclk;
    // Released lines show the inverse so stale data never passes
    assign d_i = h_oe ? h_o : f_drv ? f_d : ~f_d;
    pfhc_host pfhc_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .byte_address_lines(fa), .chip_select_n(ce_n),
        .output_gate_n(oe_n), .write_strobe_n(we_n), .flash_reset_n(frst_n),
        .reset_override_en(hv), .data_lines_o(h_o), .data_lines_oe(h_oe),
        .data_lines_i(d_i), .done_flag_i(f_rdy));
    pfhc_flash_model #(.MFR_CODE(MFR)) pfhc_flash_model_i (.addr(fa), .ce_n, .oe_n,
        .we_n, .rst_n(frst_n), .hv, .din(h_o), .dout(f_d), .drv(f_drv), .rdy(f_rdy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, e, m);
        int n;
        if (!w) begin
            eq.push_back(e);
            mq.push_back(m);
        end
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        // Answer taken at the edge that samples pready high
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        if (n == 50) begin
            mismatches++;
            stop_test();
        end
        @(posedge pclk);
    endtask
    // Scoreboard takes the oldest note as each read completes
    always @(negedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
        if (mq[0] != 0) check(prdata & mq[0], eq[0] & mq[0]);
        void'(eq.pop_front());
        void'(mq.pop_front());
    end
    task automatic wait_idle();
        int n;
        for (n = 0; n < 3000; n++) begin
            apb(0, `PFHC_STATUS_OFS, 0, 0, 0);
            if (rd[0] === 1'b0) break;
        end
        if (n == 3000) begin
            mismatches++;
            stop_test();
        end
    endtask
    task automatic run(input pfhc_op_e o, input logic [19:0] ad, input logic [7:0] wd, input logic h);
        apb(1, `PFHC_ADDR_OFS, {12'h0, ad}, 0, 0);
        apb(1, `PFHC_WDATA_OFS, {24'h0, wd}, 0, 0);
        apb(1, `PFHC_CTRL_OFS, {27'h0, h, 1'b1, o}, 0, 0);
        wait_idle();
    endtask
    task automatic rdback(input logic [19:0] ad, input logic [7:0] e);
        run(PFHC_OP_READ, ad, 0, 0);
        apb(0, `PFHC_RDATA_OFS, 0, {24'h0, e}, 32'hff);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, `PFHC_CTRL_OFS, 0, 0, 32'hffff_ffff);
        apb(0, `PFHC_STATUS_OFS, 0, 32'h2, 32'hf);
        apb(0, 12'h020, 0, 0, 0);
        check({31'h0, se}, 32'h1);
        $display("test reset done");
        seed = lfsr(seed);
        a = {4'h2, seed[15:0]};
        d = seed[23:16];
        d2 = seed[31:24];
        rdback(a, 8'hff);
        run(PFHC_OP_PROG, a, d, 0);
        rdback(a, d);
        run(PFHC_OP_PROG, a, d2, 0);
        rdback(a, d & d2);
        $display("test program done");
        run(PFHC_OP_PROG, 20'h00010, 8'h3c, 0);
        run(PFHC_OP_LOCK, 0, 0, 0);
        run(PFHC_OP_ID_ENTRY, 0, 0, 0);
        rdback(`PFHC_LOCK_STATUS_ADDR, 8'h01);
        rdback(20'h00000, MFR);
        run(PFHC_OP_ID_EXIT1, 0, 0, 0);
        rdback(20'h00010, 8'h3c);
        run(PFHC_OP_ID_ENTRY, 0, 0, 0);
        run(PFHC_OP_ID_EXIT, 0, 0, 0);
        run(PFHC_OP_PROG, 20'h00010, 8'h00, 0);
        rdback(20'h00010, 8'h3c);
        run(PFHC_OP_PROG, 20'h00010, 8'h0c, 1);
        rdback(20'h00010, 8'h0c);
        run(PFHC_OP_ERASE, 0, 0, 0);
        rdback(a, 8'hff);
        rdback(20'h00010, 8'h0c);
        $display("test lockout done");
        a = {4'h3, seed[19:4]};
        apb(1, `PFHC_ADDR_OFS, {12'h0, a}, 0, 0);
        apb(1, `PFHC_WDATA_OFS, {24'h0, d}, 0, 0);
        apb(1, `PFHC_CTRL_OFS, {28'h0, 1'b1, PFHC_OP_PROG}, 0, 0);
        for (i = 0; i < 60 && rd[2] !== 1'b1; i++) begin
            apb(1, `PFHC_CTRL_OFS, 32'h20, 0, 0);
            repeat (i % 3) @(posedge pclk);
            apb(0, `PFHC_STATUS_OFS, 0, 0, 0);
        end
        wait_idle();
        apb(0, `PFHC_STATUS_OFS, 0, 32'h4, 32'h5);
        rdback(a, d);
        run(PFHC_OP_RESET, 0, 0, 0);
        rdback(a, d);
        $display("test abort done");
        stop_test();
    end
endmodule
bind pfhc_host pfhc_host_assertions pfhc_host_assertions_i (.pclk, .presetn,
    .byte_address_lines, .chip_select_n, .output_gate_n, .write_strobe_n,
    .flash_reset_n, .data_lines_o, .data_lines_oe, .done_flag_i);
